// ---- src/cpu_instruction_execute.sv ----
/*
  Execute stage for arithmetic, logic, skip, indirect jump/call and
  flag branches. Assumes the fetch side presents one decoded instruction
  with i_valid and holds it until o_ready takes it, and supplies the
  selected I/O bit for I/O skips alongside the instruction.
*/
`timescale 1ns/100ps
module cpu_instruction_execute import exec_pkg::*; #(
  parameter int ADDR_W = PC_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire instr_s i_instr,
  input wire logic i_io_bit,
  input wire logic i_ext_we,
  input wire logic [REG_AW-1:0] i_ext_addr,
  input wire logic [DATA_W-1:0] i_ext_data,
  output logic o_ready,
  output logic o_done,
  output logic [ADDR_W-1:0] o_pc,
  output logic [DATA_W-1:0] o_status,
  output logic o_call_push,
  output logic [ADDR_W-1:0] o_call_ret
);

  typedef enum logic {st_run, st_stall} state_e;

  if (ADDR_W < Z_W) begin : g_bad_pc
    $error("PC must be at least as wide as the Z pointer");
  end

  state_e state_reg;
  logic [1:0] cnt_reg;
  logic ready_reg, done_reg, push_reg;
  logic [ADDR_W-1:0] pc_reg, ret_reg;
  logic [DATA_W-1:0] status_reg;

  wire op_e op = i_instr.op;
  wire take = i_valid & ready_reg;
  logic [DATA_W-1:0] a, rr_data;
  logic [Z_W-1:0] zptr;

  // Operation classes
  wire is_add = op == op_add || op == op_add_carry;
  wire is_cmp = op == op_cmp || op == op_cmp_carry || op == op_cmp_imm;
  wire is_sub = op == op_sub || op == op_sub_imm || op == op_sub_carry ||
                op == op_sub_imm_with_carry || is_cmp;
  wire use_c = op == op_add_carry || op == op_sub_carry ||
               op == op_sub_imm_with_carry || op == op_cmp_carry;
  wire is_andf = op == op_and || op == op_and_imm || op == op_test_op;
  wire is_orf = op == op_or || op == op_or_immediate ||
                op == op_set_bits_op;
  wire is_xor = op == op_exclusive_or;
  wire is_cbr = op == op_clear_bits_op;
  wire is_logic = is_andf || is_orf || is_xor || is_cbr;
  wire use_imm = op == op_sub_imm || op == op_sub_imm_with_carry ||
                 op == op_and_imm || op == op_or_immediate ||
                 op == op_set_bits_op || op == op_clear_bits_op ||
                 op == op_cmp_imm;
  wire is_tst = op == op_test_op;

  // Operand selection; test uses the register against itself
  wire [DATA_W-1:0] b = use_imm ? i_instr.imm :
                        (is_tst ? a : rr_data);
  wire cin = use_c & status_reg[FLAG_C];
  wire [DATA_W:0] sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  wire [DATA_W:0] diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};

  wire [DATA_W-1:0] log_res = is_andf ? (a & b) :
                              is_orf ? (a | b) :
                              is_xor ? (a ^ b) :
                              (a & ~b);
  wire [DATA_W-1:0] res = is_add ? sum[DATA_W-1:0] :
                          is_sub ? diff[DATA_W-1:0] : log_res;

  // Half-carry from operand and result bit 3, overflow from operand and result sign bits
  wire h_add = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
  wire v_add = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
  wire h_sub = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
  wire v_sub = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);

  // Carry-chained subtracts only keep Z if it was already set
  wire z_raw = res == 8'h00;
  wire f_z = (is_sub && use_c) ? (z_raw & status_reg[FLAG_Z]) : z_raw;
  wire f_n = res[7];
  wire f_v = is_add ? v_add : (is_sub ? v_sub : 1'b0);
  wire f_s = f_n ^ f_v;
  wire f_h = is_logic ? status_reg[FLAG_H] : (is_add ? h_add : h_sub);
  wire f_c = is_logic ? status_reg[FLAG_C] : (is_add ? sum[8] : diff[8]);
  wire [DATA_W-1:0] status_alu = {status_reg[FLAG_I], status_reg[FLAG_T],
                                  f_h, f_s, f_v, f_n, f_z, f_c};
  wire alu_op = is_add || is_sub || is_logic;
  wire alu_we = take && alu_op && !is_cmp;
  wire rf_we = alu_we || (i_ext_we && !alu_we);
  wire [REG_AW-1:0] rf_waddr = alu_we ? i_instr.rd : i_ext_addr;
  wire [DATA_W-1:0] rf_wdata = alu_we ? res : i_ext_data;

  // Skips and branches
  wire rbit = rr_data[i_instr.bit_sel];
  wire skip_go = (op == op_compare_skip_equal && a == rr_data) ||
                 (op == op_skip_reg_bit_clear && !rbit) ||
                 (op == op_skip_reg_bit_set && rbit) ||
                 (op == op_skip_io_bit_clear && !i_io_bit) ||
                 (op == op_skip_io_bit_set && i_io_bit);
  wire fbit = status_reg[i_instr.bit_sel];
  wire br_go = (op == op_branch_flag_set && fbit) ||
               (op == op_branch_flag_clear && !fbit);
  wire is_ind = op == op_indirect_jump || op == op_indirect_call;

  wire [ADDR_W-1:0] pc_inc = pc_reg + ADDR_W'(1);
  wire [ADDR_W-1:0] pc_skip = pc_reg + ADDR_W'(2) +
                              ADDR_W'(i_instr.next_two_word);
  wire [ADDR_W-1:0] k_ext = {{(ADDR_W-OFS_W){i_instr.offset[6]}},
                             i_instr.offset};
  wire [ADDR_W-1:0] pc_br = pc_reg + k_ext + ADDR_W'(1);
  wire [ADDR_W-1:0] pc_z = {{(ADDR_W-Z_W){1'b0}}, zptr};
  wire [ADDR_W-1:0] pc_next = is_ind ? pc_z : br_go ? pc_br :
                              skip_go ? pc_skip : pc_inc;

  // Extra cycles beyond the issue cycle
  wire [1:0] extra = op == op_indirect_jump ? JUMP_EXTRA :
                     op == op_indirect_call ? CALL_EXTRA :
                     br_go ? BRANCH_EXTRA :
                     skip_go ? SKIP_EXTRA + 2'(i_instr.next_two_word) :
                     2'h0;

  exec_regfile u_regs (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_we(rf_we),
    .i_waddr(rf_waddr),
    .i_wdata(rf_wdata),
    .i_raddr_a(i_instr.rd),
    .i_raddr_b(i_instr.rr),
    .o_rdata_a(a),
    .o_rdata_b(rr_data),
    .o_zptr(zptr)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pc_reg <= '0;
      status_reg <= STATUS_RST;
      ret_reg <= '0;
    end else if (take) begin
      pc_reg <= pc_next;
      if (alu_op) begin
        status_reg <= status_alu;
      end
      if (op == op_indirect_call) begin
        ret_reg <= pc_inc;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg <= st_run;
      cnt_reg <= 2'h0;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      push_reg <= 1'b0;
    end else begin
      push_reg <= take && op == op_indirect_call;
      done_reg <= 1'b0;
      unique case (state_reg)
        st_run: begin
          if (take && extra != 2'h0) begin
            state_reg <= st_stall;
            cnt_reg <= extra;
            ready_reg <= 1'b0;
          end else if (take) begin
            done_reg <= 1'b1;
          end
        end
        st_stall: begin
          cnt_reg <= cnt_reg - 2'h1;
          if (cnt_reg == 2'h1) begin
            state_reg <= st_run;
            ready_reg <= 1'b1;
            done_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  assign o_ready = ready_reg;
  assign o_done = done_reg;
  assign o_pc = pc_reg;
  assign o_status = status_reg;
  assign o_call_push = push_reg;
  assign o_call_ret = ret_reg;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_add_carry: assert property (take && op == op_add |=>
    o_status[FLAG_C] == $past(sum[8]) && o_done)
    else $error("add carry or timing wrong");
  a_and_imm_flags: assert property (take && op == op_and_imm |=>
    !o_status[FLAG_V] && o_status[FLAG_C] == $past(status_reg[FLAG_C]))
    else $error("and immediate flags wrong");
  a_or_xor_write: assert property (
    take && (op == op_or || op == op_exclusive_or) |->
    rf_we && rf_waddr == i_instr.rd)
    else $error("or/xor result not written");
  a_set_bits_val: assert property (
    take && op == op_set_bits_op |-> rf_wdata == (a | i_instr.imm))
    else $error("set bits value wrong");
  a_clear_bits_val: assert property (
    take && op == op_clear_bits_op |-> rf_wdata == (a & ~i_instr.imm))
    else $error("clear bits value wrong");
  a_test_zero: assert property (take && is_tst |=>
    o_status[FLAG_Z] == ($past(a) == 8'h00) &&
    o_status[FLAG_S] == o_status[FLAG_N])
    else $error("test flags wrong");
  a_jump_target: assert property (take && op == op_indirect_jump |=>
    o_pc == ADDR_W'($past(zptr)) && !o_ready ##1 o_ready && o_done)
    else $error("indirect jump target or length wrong");
  a_call_length: assert property (take && op == op_indirect_call |=>
    !o_ready [*2] ##1 o_ready && o_done)
    else $error("indirect call length wrong");
  a_compare_skip_equal_skip: assert property (take && op == op_compare_skip_equal &&
    a == rr_data && !i_instr.next_two_word |=>
    o_pc == $past(pc_reg) + ADDR_W'(2) ##1 o_ready)
    else $error("compare skip wrong");
  a_reg_skip_len: assert property (take &&
    (op == op_skip_reg_bit_clear || op == op_skip_reg_bit_set) &&
    skip_go && i_instr.next_two_word |=> !o_ready [*2] ##1 o_ready)
    else $error("register bit skip length wrong");
  a_io_skip_none: assert property (take && !skip_go &&
    (op == op_skip_io_bit_clear || op == op_skip_io_bit_set) |=>
    o_ready && o_pc == $past(pc_reg) + ADDR_W'(1))
    else $error("io skip fell through wrongly");
  a_branch_taken: assert property (take && br_go &&
    op == op_branch_flag_set |=> o_pc == $past(pc_br) ##1 o_done)
    else $error("branch on set wrong");
  a_branch_fall: assert property (take && !br_go &&
    op == op_branch_flag_clear |=> o_ready && o_done)
    else $error("branch on clear not one cycle");
  a_cmp_nowrite: assert property (
    take && is_cmp && !i_ext_we |-> !rf_we)
    else $error("compare wrote register");

  c_call: cover property (take && op == op_indirect_call ##3 o_ready);
  c_skip_two: cover property (take && skip_go && i_instr.next_two_word);
  c_branch: cover property (take && br_go);
  c_sub_carry: cover property (take && op == op_sub_carry && diff[8]);

endmodule

// ---- src/exec_pkg.sv ----
/*
  Shared constants and types for the instruction execute unit.
  Assumes an 8-bit datapath, sixteen working registers and a 22-bit PC.
*/
package exec_pkg;

  localparam int DATA_W = 8;
  localparam int REG_CNT = 16;
  localparam int REG_AW = 4;
  localparam int PC_W = 22;
  localparam int Z_W = 16;
  localparam int OFS_W = 7;

  // Z pointer pair sits in the two top working registers
  localparam logic [3:0] ZL_IDX = 4'hE;
  localparam logic [3:0] ZH_IDX = 4'hF;

  // Status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;

  // Cycle counts, minus the issue cycle
  localparam logic [1:0] JUMP_EXTRA = 2'h1;
  localparam logic [1:0] CALL_EXTRA = 2'h2;
  localparam logic [1:0] BRANCH_EXTRA = 2'h1;
  localparam logic [1:0] SKIP_EXTRA = 2'h1;

  typedef enum logic [4:0] {
    op_nop,
    op_add,
    op_add_carry,
    op_sub,
    op_sub_imm,
    op_sub_carry,
    op_sub_imm_with_carry,
    op_and,
    op_and_imm,
    op_or,
    op_or_immediate,
    op_exclusive_or,
    op_set_bits_op,
    op_clear_bits_op,
    op_test_op,
    op_cmp,
    op_cmp_carry,
    op_cmp_imm,
    op_indirect_jump,
    op_indirect_call,
    op_compare_skip_equal,
    op_skip_reg_bit_clear,
    op_skip_reg_bit_set,
    op_skip_io_bit_clear,
    op_skip_io_bit_set,
    op_branch_flag_set,
    op_branch_flag_clear
  } op_e;

  typedef struct packed {
    op_e op;
    logic [3:0] rd;
    logic [3:0] rr;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [6:0] offset;
    logic next_two_word;
  } instr_s;

endpackage

// ---- src/exec_regfile.sv ----
/*
  Working register file: one write port, two read ports, Z pointer tap.
  Assumes the caller arbitrates between writers.
*/
`timescale 1ns/100ps
module exec_regfile import exec_pkg::*; #(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = REG_CNT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [REG_AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [REG_AW-1:0] i_raddr_a,
  input wire logic [REG_AW-1:0] i_raddr_b,
  output logic [WIDTH-1:0] o_rdata_a,
  output logic [WIDTH-1:0] o_rdata_b,
  output logic [2*WIDTH-1:0] o_zptr
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  if (DEPTH != (1 << REG_AW)) begin : g_bad_depth
    $error("Register file depth must match address width");
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
        mem_reg[i] <= WIDTH'(REG_RST);
      end else if (i_we && i_waddr == REG_AW'(i)) begin
        mem_reg[i] <= i_wdata;
      end
    end
  end

  // Combinational read keeps ALU operations to one cycle
  assign o_rdata_a = mem_reg[i_raddr_a];
  assign o_rdata_b = mem_reg[i_raddr_b];
  assign o_zptr = {mem_reg[ZH_IDX], mem_reg[ZL_IDX]};

endmodule

// ---- tb/cpu_instruction_execute_bench.sv ----
/*
  Self-checking bench for the instruction execute unit.
  Assumes the unit's own assertions sit in its source; operands are
  loaded through the external register write port.
*/
`timescale 1ns/100ps
module cpu_instruction_execute_bench;
  import exec_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic valid = 1'b0;
  instr_s instr = '0;
  logic io_bit = 1'b0;
  logic ext_we = 1'b0;
  logic [3:0] ext_addr = 4'h0;
  logic [7:0] ext_data = 8'h00;
  logic ready, done, call_push;
  logic [PC_W-1:0] pc, call_ret;
  logic [7:0] status;
  int bad_count = 0;
  int checks = 0;
  int push_cnt;
  int n;
  logic [PC_W-1:0] pcx = '0;
  logic [7:0] stx = STATUS_RST;

  cpu_instruction_execute cpu_instruction_execute_i (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_valid(valid), .i_instr(instr),
    .i_io_bit(io_bit), .i_ext_we(ext_we), .i_ext_addr(ext_addr),
    .i_ext_data(ext_data), .o_ready(ready), .o_done(done), .o_pc(pc),
    .o_status(status), .o_call_push(call_push), .o_call_ret(call_ret)
  );

  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    ext_we = 1'b1; ext_addr = a; ext_data = d;
    @(negedge clk_sys);
    ext_we = 1'b0;
  endtask

  function automatic instr_s mk(input op_e op, input logic [3:0] rd,
      input logic [3:0] rr, input logic [7:0] imm, input logic [2:0] b,
      input logic [6:0] ofs, input logic nw);
    instr_s s;
    s = '{op: op, rd: rd, rr: rr, imm: imm, bit_sel: b, offset: ofs,
          next_two_word: nw};
    return s;
  endfunction

  // Cycles from take to the done pulse, counting the take cycle's successor
  task automatic exec(input instr_s ins, output int cyc);
    int w;
    @(negedge clk_sys);
    valid = 1'b1; instr = ins; w = 0;
    while (ready !== 1'b1 && w < 20) begin
      @(negedge clk_sys);
      w++;
    end
    // A stuck ready is a failure in its own right
    if (w >= 20) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, ready, 1'b1);
    end
    @(negedge clk_sys);
    valid = 1'b0; cyc = 1; push_cnt = (call_push === 1'b1) ? 1 : 0;
    while (done !== 1'b1 && cyc < 8) begin
      @(negedge clk_sys);
      cyc++;
      if (call_push === 1'b1) push_cnt++;
    end
  endtask

  // Returns {result, status}; compares hand back the untouched operand
  function automatic logic [15:0] ref_alu(input op_e op,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] st);
    logic [8:0] w;
    logic [4:0] h;
    logic [7:0] r, s;
    logic cin, sub, lg, chain;
    s = st; cin = 1'b0; sub = 1'b0; lg = 1'b1; chain = 1'b0; r = a;
    case (op)
      op_add: lg = 1'b0;
      op_add_carry: begin lg = 1'b0; cin = st[FLAG_C]; end
      op_sub, op_sub_imm, op_cmp, op_cmp_imm: begin lg = 1'b0; sub = 1'b1; end
      op_sub_carry, op_sub_imm_with_carry, op_cmp_carry: begin
        lg = 1'b0; sub = 1'b1; cin = st[FLAG_C]; chain = 1'b1;
      end
      op_and, op_and_imm: r = a & b;
      op_test_op: r = a;
      op_or, op_or_immediate, op_set_bits_op: r = a | b;
      op_exclusive_or: r = a ^ b;
      default: r = a & ~b;
    endcase
    if (lg) begin
      s[FLAG_V] = 1'b0; s[FLAG_N] = r[7]; s[FLAG_S] = r[7];
      s[FLAG_Z] = (r == 8'h00);
    end else begin
      if (sub) begin
        w = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      end else begin
        w = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      end
      r = w[7:0]; s[FLAG_C] = w[8]; s[FLAG_H] = h[4]; s[FLAG_N] = r[7];
      s[FLAG_V] = sub ? (a[7] != b[7]) && (r[7] != a[7])
                      : (a[7] == b[7]) && (r[7] != a[7]);
      s[FLAG_S] = s[FLAG_N] ^ s[FLAG_V];
      // Chained subtract keeps Z only if it was already set
      s[FLAG_Z] = (r == 8'h00) && (!chain || st[FLAG_Z]);
      if (op inside {op_cmp, op_cmp_carry, op_cmp_imm}) r = a;
    end
    return {r, s};
  endfunction

  task automatic t_reset;
    chk(pc, 32'h0);
    chk(status, STATUS_RST);
    chk({ready, done, call_push}, 32'h4);
    chk(call_ret, 32'h0);
    $display("test reset done");
  endtask

  op_e tab_op[18] = '{op_add, op_add_carry, op_add_carry, op_sub, op_sub_imm,
    op_sub_carry, op_sub_imm_with_carry, op_cmp, op_cmp_carry, op_cmp_imm,
    op_and, op_and_imm, op_or, op_or_immediate, op_exclusive_or,
    op_set_bits_op, op_clear_bits_op, op_test_op};
  logic [7:0] tab_a[18] = '{8'h7F, 8'hF0, 8'h0F, 8'h10, 8'h00, 8'h05, 8'h80,
    8'h22, 8'h22, 8'h01, 8'h5A, 8'hF0, 8'h80, 8'h00, 8'hFF, 8'h01, 8'hFF,
    8'h80};
  logic [7:0] tab_b[18] = '{8'h01, 8'h20, 8'h01, 8'h10, 8'h01, 8'h04, 8'h01,
    8'h22, 8'h22, 8'h02, 8'h0F, 8'h0F, 8'h01, 8'h00, 8'h0F, 8'h80, 8'h0F,
    8'h0F};

  // Result read back by compare-skip against a reference register
  // Test gets a differing second register so it must ignore that operand
  task automatic t_alu;
    logic [15:0] e;
    for (int i = 0; i < 18; i++) begin
      wr(4'h1, tab_a[i]);
      wr(4'h2, tab_b[i]);
      e = ref_alu(tab_op[i], tab_a[i], tab_b[i], stx);
      exec(mk(tab_op[i], 4'h1, 4'h2, tab_b[i], 3'h0, 7'h00, 1'b0), n);
      stx = e[7:0]; pcx = pcx + 22'h1;
      chk(status, stx);
      chk({pc, n[3:0]}, {pcx, 4'h1});
      wr(4'h3, e[15:8]);
      exec(mk(op_compare_skip_equal, 4'h1, 4'h3, 8'h00, 3'h0, 7'h00, 1'b0), n);
      pcx = pcx + 22'h2;
      chk({pc, n[3:0], status}, {pcx, 4'h2, stx});
    end
    $display("test alu done");
  endtask

  task automatic t_jump_call;
    logic [PC_W-1:0] ret;
    wr(ZL_IDX, 8'h34);
    wr(ZH_IDX, 8'h12);
    exec(mk(op_indirect_jump, 4'h0, 4'h0, 8'h00, 3'h0, 7'h00, 1'b0), n);
    chk({pc, n[3:0], status}, {22'h001234, 4'h2, stx});
    wr(ZL_IDX, 8'hFE);
    wr(ZH_IDX, 8'hAB);
    ret = pc + 22'h1;
    exec(mk(op_indirect_call, 4'h0, 4'h0, 8'h00, 3'h0, 7'h00, 1'b0), n);
    chk({pc, n[3:0], status}, {22'h00ABFE, 4'h3, stx});
    chk(call_ret, ret);
    chk(push_cnt, 32'h1);
    pcx = 22'h00ABFE;
    $display("test jump and call done");
  endtask

  op_e sk_op[4] = '{op_skip_reg_bit_clear, op_skip_reg_bit_set,
    op_skip_io_bit_clear, op_skip_io_bit_set};

  task automatic t_skips;
    logic bv, skip;
    logic [2:0] adv;
    wr(4'h4, 8'hA5);
    for (int k = 0; k < 4; k++)
      for (int v = 0; v < 8; v++)
        for (int nw = 0; nw < 2; nw++) begin
          io_bit = v[0];
          bv = (k < 2) ? 1'(8'hA5 >> v) : v[0];
          skip = ((k % 2) == 1) == bv;
          adv = skip ? (nw ? 3'h3 : 3'h2) : 3'h1;
          exec(mk(sk_op[k], 4'h0, 4'h4, 8'h00, v[2:0], 7'h00, nw[0]), n);
          pcx = pcx + 22'(adv);
          chk({pc, n[3:0]}, {pcx, 1'b0, adv});
        end
    exec(mk(op_compare_skip_equal, 4'h4, 4'h5, 8'h00, 3'h0, 7'h00, 1'b0), n);
    pcx = pcx + 22'h1;
    chk({pc, n[3:0]}, {pcx, 4'h1});
    exec(mk(op_compare_skip_equal, 4'h4, 4'h4, 8'h00, 3'h0, 7'h00, 1'b1), n);
    pcx = pcx + 22'h3;
    chk({pc, n[3:0], status}, {pcx, 4'h3, stx});
    $display("test skips done");
  endtask

  task automatic t_branch;
    logic taken;
    logic [6:0] ofs;
    for (int k = 0; k < 2; k++)
      for (int b = 0; b < 8; b++) begin
        ofs = b[0] ? 7'h7C : 7'h05;
        taken = (k == 0) == stx[b];
        exec(mk(k == 0 ? op_branch_flag_set : op_branch_flag_clear, 4'h0,
                4'h0, 8'h00, b[2:0], ofs, 1'b0), n);
        pcx = taken ? pcx + {{15{ofs[6]}}, ofs} + 22'h1 : pcx + 22'h1;
        chk({pc, n[3:0]}, {pcx, taken ? 4'h2 : 4'h1});
        chk(status, stx);
      end
    $display("test branch done");
  endtask

  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #200us;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_alu();
    t_jump_call();
    t_skips();
    t_branch();
    tally_and_finish();
  end
endmodule
